// ===== design/scp_pkg.sv
// constants, field layouts and carrier types of the sleep clock block
// assumes one 100 MHz clock domain and an apb register port
package scp_pkg;

    // **********************************************************
    // register map (byte addresses, one word per register)
    // **********************************************************
    localparam int SCP_ADDR_W = 12;
    localparam logic [11:0] SCP_PCG_OFS = 12'h000; // clock gate register
    localparam logic [11:0] SCP_SLEEP_OFS = 12'h004; // sleep mode select
    localparam logic [11:0] SCP_STAT_OFS = 12'h008; // read-only state

    // **********************************************************
    // clock gate register fields
    // **********************************************************
    localparam int SCP_BIT_TWO_WIRE = 7;
    localparam int SCP_BIT_TIMER_TWO = 6;
    localparam int SCP_BIT_TIMER_ZERO = 5;
    localparam int SCP_BIT_RESERVED = 4;
    localparam int SCP_BIT_TIMER_ONE = 3;
    localparam int SCP_BIT_SERIAL_PERIPH = 2;
    localparam int SCP_BIT_ASYNC_SERIAL = 1;
    localparam int SCP_BIT_CONVERTER = 0;
    localparam logic [7:0] SCP_PCG_RESET = 8'h00;
    localparam logic [7:0] SCP_PCG_WMASK = 8'hEF; // bit 4 never stored

    // **********************************************************
    // sleep mode codes and status fields
    // **********************************************************
    localparam logic [2:0] SCP_MODE_IDLE = 3'h0;
    localparam logic [2:0] SCP_MODE_ADC_NR = 3'h1;
    localparam logic [2:0] SCP_MODE_PDOWN = 3'h2;
    localparam logic [2:0] SCP_MODE_PSAVE = 3'h3;
    localparam logic [2:0] SCP_MODE_STANDBY = 3'h6;
    localparam logic [2:0] SCP_SLEEP_RESET = 3'h0;
    localparam int SCP_STAT_STATE_LSB = 8;
    localparam int SCP_STAT_MODE_LSB = 10;

    // **********************************************************
    // wake timing in clock cycles
    // **********************************************************
    localparam int SCP_WAKE_W = 8;
    localparam int SCP_STANDBY_WAKE_CYC = 6;
    localparam int SCP_FAST_WAKE_CYC = 1;
    localparam int SCP_DEEP_WAKE_CYC = 16;

    // power state of the core
    typedef enum logic [1:0] {
        SCP_ST_ACTIVE = 2'b00,
        SCP_ST_SLEEP = 2'b01,
        SCP_ST_WAKE = 2'b10
    } scp_state_type;

    // wake sources seen by the sleep logic
    typedef struct packed {
        logic [1:0] ext_level; // level form of the two external lines
        logic [1:0] ext_edge; // edge form of the two external lines
        logic pin_change;
        logic twi_match; // two-wire address match
        logic t2_ovf;
        logic t2_cmp;
        logic t2_ovf_ie;
        logic t2_cmp_ie;
        logic global_ie;
        logic spm_ready; // self-program / eeprom ready
        logic adc_done;
        logic watchdog;
        logic other_io;
    } scp_wake_type;

    // clock domain and oscillator enables
    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic asy;
        logic main_osc;
        logic timer_osc;
    } scp_clk_type;

endpackage

// ===== design/scp_wake_timer.sv
// down counter that times the wake-up delay after a sleep exit
// assumes the loader gives a count of at least one
module scp_wake_timer #(
    parameter int WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    output logic done
);

    logic [WIDTH-1:0] cnt_q; // cycles left
    logic [WIDTH-1:0] cnt_d;

    // **********************************************************
    // next count
    // **********************************************************
    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = load_val;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - WIDTH'(1);
        end
    end

    // done marks the last cycle of the delay
    assign done = (cnt_q == WIDTH'(1));

    // **********************************************************
    // count register
    // **********************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

// ===== design/scp_sleep_ctrl.sv
// sleep mode clock gating and per-peripheral clock gate, apb slave
// assumes the cpu pulses sleep_req when it runs the sleep instruction
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
module scp_sleep_ctrl
    import scp_pkg::*;
#(
    parameter int DEEP_WAKE_CYC = SCP_DEEP_WAKE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [SCP_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sleep_req,
    input wire logic crystal_selected,
    input wire logic timer_two_async_select,
    input wire logic adc_enable,
    input wire logic adc_conv_done,
    input wire scp_wake_type wake_src,
    output scp_clk_type dom_clk_en,
    output logic [7:0] periph_clk_en,
    output logic [7:0] periph_reg_access,
    output logic comparator_mux_allow,
    output logic adc_powered,
    output logic adc_extended_conv,
    output logic sleeping,
    output logic wake_pulse
);

    // **********************************************************
    // decode helpers
    // **********************************************************

    // wake sources that each mode honours
    function automatic logic wake_ok(logic [2:0] m, scp_wake_type w);
        logic base;
        logic t2;
        base = (|w.ext_level) | w.pin_change | w.twi_match | w.watchdog;
        t2 = ((w.t2_ovf & w.t2_ovf_ie) | (w.t2_cmp & w.t2_cmp_ie))
            & w.global_ie;
        unique case (m)
            SCP_MODE_IDLE: wake_ok = base | (|w.ext_edge) | t2
                | w.spm_ready | w.adc_done | w.other_io;
            SCP_MODE_ADC_NR: wake_ok = base | t2 | w.spm_ready
                | w.adc_done;
            SCP_MODE_PSAVE: wake_ok = base | t2;
            default: wake_ok = base; // power-down and standby
        endcase
    endfunction

    // clock domains kept alive while not active
    function automatic scp_clk_type sleep_clocks(logic [2:0] m,
                                                 logic async_t2);
        scp_clk_type c;
        c = '0;
        unique case (m)
            SCP_MODE_IDLE: begin
                c.io = 1'b1;
                c.adc = 1'b1;
                c.asy = 1'b1;
                c.main_osc = 1'b1;
                c.timer_osc = async_t2;
            end
            SCP_MODE_ADC_NR: begin
                c.adc = 1'b1;
                c.asy = 1'b1;
                c.main_osc = 1'b1;
                c.timer_osc = async_t2;
            end
            SCP_MODE_PSAVE: begin
                c.asy = 1'b1;
                c.timer_osc = 1'b1;
            end
            SCP_MODE_STANDBY: c.main_osc = 1'b1;
            default: c = '0; // power-down keeps nothing
        endcase
        sleep_clocks = c;
    endfunction

    // **********************************************************
    // state
    // **********************************************************
    scp_state_type state_q, state_d; // power state
    logic [2:0] mode_q, mode_d; // mode latched at sleep entry
    logic [2:0] sel_q, sel_d; // sleep mode select field
    logic [7:0] pcg_q, pcg_d; // peripheral clock gate register
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    scp_clk_type clk_q, clk_d;
    logic [7:0] pclk_en_q, pclk_en_d;
    logic [7:0] racc_q, racc_d;
    logic mux_q, mux_d;
    logic adc_on_q, adc_on_d;
    logic ext_q, ext_d; // next conversion is an extended one
    logic adc_seen_q, adc_seen_d; // adc_enable one cycle ago
    logic wake_q, wake_d;
    logic sleep_q, sleep_d; // core not in the active state
    logic tmr_load;
    logic [SCP_WAKE_W-1:0] tmr_val;
    logic tmr_done;
    logic setup;
    logic access;
    logic legal;
    logic wake_hit;

    // **********************************************************
    // apb slave, zero wait beyond the first access cycle
    // **********************************************************
    assign setup = psel & ~penable;
    assign access = psel & penable & pready_q;

    // bus responses and register writes
    always_comb begin
        pready_d = setup;
        pslverr_d = 1'b0;
        prdata_d = prdata_q;
        pcg_d = pcg_q;
        sel_d = sel_q;
        if (setup) begin
            prdata_d = '0;
            unique case (paddr)
                SCP_PCG_OFS: prdata_d[7:0] = pcg_q & SCP_PCG_WMASK;
                SCP_SLEEP_OFS: prdata_d[2:0] = sel_q;
                SCP_STAT_OFS: begin
                    prdata_d[6:0] = clk_q;
                    prdata_d[SCP_STAT_STATE_LSB +: 2] = state_q;
                    prdata_d[SCP_STAT_MODE_LSB +: 3] = mode_q;
                end
                default: pslverr_d = 1'b1; // unmapped address
            endcase
        end
        if (access && pwrite) begin
            if (paddr == SCP_PCG_OFS) begin
                pcg_d = pwdata[7:0] & SCP_PCG_WMASK;
            end
            if (paddr == SCP_SLEEP_OFS) begin
                sel_d = pwdata[2:0];
            end
        end
    end

    // **********************************************************
    // sleep sequencer
    // **********************************************************

    // standby needs a crystal; legal codes
    assign legal = (sel_q == SCP_MODE_IDLE) || (sel_q == SCP_MODE_ADC_NR)
        || (sel_q == SCP_MODE_PDOWN) || (sel_q == SCP_MODE_PSAVE)
        || ((sel_q == SCP_MODE_STANDBY) && crystal_selected);
    assign wake_hit = wake_ok(mode_q, wake_src);

    // next power state and wake delay load
    always_comb begin
        state_d = state_q;
        mode_d = mode_q;
        tmr_load = 1'b0;
        tmr_val = SCP_WAKE_W'(SCP_FAST_WAKE_CYC);
        wake_d = 1'b0;
        unique case (state_q)
            SCP_ST_ACTIVE: begin
                if (sleep_req && legal) begin
                    state_d = SCP_ST_SLEEP;
                    mode_d = sel_q;
                end
            end
            SCP_ST_SLEEP: begin
                if (wake_hit) begin
                    state_d = SCP_ST_WAKE;
                    tmr_load = 1'b1;
                    if (mode_q == SCP_MODE_STANDBY) begin
                        tmr_val = SCP_WAKE_W'(SCP_STANDBY_WAKE_CYC);
                    end else if (mode_q == SCP_MODE_PDOWN
                                 || mode_q == SCP_MODE_PSAVE) begin
                        // oscillator restarted, wait for it
                        tmr_val = SCP_WAKE_W'(DEEP_WAKE_CYC);
                    end
                end
            end
            SCP_ST_WAKE: begin
                if (tmr_done) begin
                    state_d = SCP_ST_ACTIVE;
                    wake_d = 1'b1;
                end
            end
            default: state_d = SCP_ST_ACTIVE; // illegal code recovers
        endcase
    end

    // wake delay counter
    scp_wake_timer #(
        .WIDTH(SCP_WAKE_W)
    ) u_wake_timer (
        .pclk(pclk),
        .presetn(presetn),
        .load(tmr_load),
        .load_val(tmr_val),
        .done(tmr_done)
    );

    // **********************************************************
    // clock enables, gates and converter control
    // **********************************************************
    always_comb begin
        if (state_d == SCP_ST_ACTIVE) begin
            clk_d = '1;
            clk_d.timer_osc = timer_two_async_select;
        end else begin
            clk_d = sleep_clocks(mode_d, timer_two_async_select);
        end
        // sleeping flag registered so the output comes from a flop
        sleep_d = (state_d != SCP_ST_ACTIVE);
        // gates act on the io domain, the converter gate on the adc domain
        for (int i = 0; i < 8; i++) begin
            pclk_en_d[i] = clk_d.io & ~pcg_d[i];
            racc_d[i] = ~pcg_d[i];
        end
        pclk_en_d[SCP_BIT_RESERVED] = 1'b0;
        racc_d[SCP_BIT_RESERVED] = 1'b0;
        pclk_en_d[SCP_BIT_CONVERTER] = clk_d.adc
            & ~pcg_d[SCP_BIT_CONVERTER];
        // asynchronous timer two clock ignores its gate; its register access still follows it
        if (timer_two_async_select) begin
            pclk_en_d[SCP_BIT_TIMER_TWO] = clk_d.asy;
        end
        mux_d = ~pcg_d[SCP_BIT_CONVERTER];
        adc_on_d = adc_enable;
        adc_seen_d = adc_enable;
        ext_d = ext_q;
        if (adc_conv_done) begin
            ext_d = 1'b0;
        end
        // set wins over the clear by a finished conversion
        if (adc_enable && !adc_seen_q) begin
            ext_d = 1'b1;
        end
    end

    // **********************************************************
    // registers
    // **********************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= SCP_ST_ACTIVE;
            mode_q <= SCP_MODE_IDLE;
            sel_q <= SCP_SLEEP_RESET;
            pcg_q <= SCP_PCG_RESET;
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            clk_q <= '1;
            pclk_en_q <= 8'hEF;
            racc_q <= 8'hEF;
            mux_q <= 1'b1;
            adc_on_q <= 1'b0;
            ext_q <= 1'b1; // first conversion after power up
            adc_seen_q <= 1'b0;
            wake_q <= 1'b0;
            sleep_q <= 1'b0;
        end else begin
            state_q <= state_d;
            mode_q <= mode_d;
            sel_q <= sel_d;
            pcg_q <= pcg_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            clk_q <= clk_d;
            pclk_en_q <= pclk_en_d;
            racc_q <= racc_d;
            mux_q <= mux_d;
            adc_on_q <= adc_on_d;
            ext_q <= ext_d;
            adc_seen_q <= adc_seen_d;
            wake_q <= wake_d;
            sleep_q <= sleep_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign dom_clk_en = clk_q;
    assign periph_clk_en = pclk_en_q;
    assign periph_reg_access = racc_q;
    assign comparator_mux_allow = mux_q;
    assign adc_powered = adc_on_q;
    assign adc_extended_conv = ext_q;
    assign sleeping = sleep_q;
    assign wake_pulse = wake_q;

    // **********************************************************
    // assertions
    // **********************************************************
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    standby_entry_a: assert property (
        state_q == SCP_ST_ACTIVE && sleep_req && crystal_selected
        && sel_q == SCP_MODE_STANDBY |=> state_q == SCP_ST_SLEEP
        && mode_q == SCP_MODE_STANDBY && clk_q.main_osc && !clk_q.io)
        else $error("standby not entered");
    standby_wake_a: assert property (
        state_q == SCP_ST_SLEEP && mode_q == SCP_MODE_STANDBY && wake_hit
        |=> (state_q == SCP_ST_WAKE) [*6] ##1 state_q == SCP_ST_ACTIVE
        && wake_pulse)
        else $error("standby wake not six cycles");
    core_clocks_a: assert property (
        state_q != SCP_ST_ACTIVE |-> !clk_q.cpu && !clk_q.flash)
        else $error("core clock running in sleep");
    edge_ignored_a: assert property (
        state_q == SCP_ST_SLEEP && mode_q == SCP_MODE_PDOWN
        && wake_src.ext_level == 2'b00 && !wake_src.pin_change
        && !wake_src.twi_match && !wake_src.watchdog
        |=> state_q == SCP_ST_SLEEP)
        else $error("power-down woke on illegal source");
    timer_osc_a: assert property (
        state_q == SCP_ST_ACTIVE ##1 state_q == SCP_ST_SLEEP
        && mode_q == SCP_MODE_IDLE && !$past(timer_two_async_select)
        |-> !clk_q.timer_osc)
        else $error("timer oscillator left on in idle");
    gate_stop_a: assert property (
        access && pwrite && paddr == SCP_PCG_OFS && pwdata[1]
        |=> !periph_clk_en[1] && !periph_reg_access[1])
        else $error("gated peripheral still clocked");
    ungate_a: assert property (
        $fell(pcg_q[SCP_BIT_TIMER_ZERO]) && state_q == SCP_ST_ACTIVE
        |-> periph_clk_en[SCP_BIT_TIMER_ZERO])
        else $error("peripheral not restarted");
    rsvd_zero_a: assert property (
        pready && $past(paddr) == SCP_PCG_OFS |-> prdata[4] == 1'b0)
        else $error("reserved bit read as one");
    async_t2_a: assert property (
        $past(timer_two_async_select) |-> periph_clk_en[6] == clk_q.asy)
        else $error("asynchronous timer two gated");
    mux_lock_a: assert property (
        pcg_q[SCP_BIT_CONVERTER] |-> !comparator_mux_allow)
        else $error("comparator mux usable while gated");
    reserved_code_a: assert property (
        state_q == SCP_ST_ACTIVE && sleep_req && sel_q[2] && !legal
        |=> state_q == SCP_ST_ACTIVE && $stable(clk_q))
        else $error("reserved code changed clocks");

    standby_seen_c: cover property (
        state_q == SCP_ST_SLEEP && mode_q == SCP_MODE_STANDBY);
    wake_seen_c: cover property (wake_pulse);
    gate_write_c: cover property (access && pwrite
        && paddr == SCP_PCG_OFS);

endmodule

// ===== bench/tb_top.sv
// self-checking bench for the sleep clock and clock gate block
// assumes the design package is compiled first; drives the apb port,
// the sleep request and the wake sources directly, with no partner model
module tb_top
    import scp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // signals and tables
    // ************************************************************
    localparam int DEEP = 4; // shortened oscillator restart count
    logic pclk, presetn, psel, penable, pwrite, sleep_req;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, err, crystal_selected, timer_two_async_select;
    logic adc_enable, adc_conv_done, comparator_mux_allow, adc_powered;
    logic adc_extended_conv, sleeping, wake_pulse;
    logic [7:0] periph_clk_en, periph_reg_access;
    scp_wake_type wake_src;
    scp_clk_type dom_clk_en;
    int error_cnt = 0;
    int total_checks = 0;
    // per mode: code, clocks, gated clocks, refused and accepted source
    logic [2:0] m_code [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h0};
    logic [6:0] m_clk [6] = '{7'h1E, 7'h0E, 7'h00, 7'h05, 7'h02, 7'h1F};
    logic [7:0] m_pcg [6] = '{8'hEF, 8'h01, 8'h00, 8'h00, 8'h00, 8'hEF};
    logic [14:0] m_rej [6] = '{15'h0, 15'h0001, 15'h0800, 15'h0140,
                               15'h0150, 15'h0};
    logic [14:0] m_acc [6] = '{15'h0800, 15'h0004, 15'h2000, 15'h0150,
                               15'h0002, 15'h0001};
    int m_lat [6] = '{2, 2, DEEP + 1, DEEP + 1, 7, 2};

    // free running 100 MHz clock
    always #5 pclk = ~pclk;

    scp_sleep_ctrl #(.DEEP_WAKE_CYC(DEEP)) dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_req(sleep_req), .crystal_selected(crystal_selected),
        .timer_two_async_select(timer_two_async_select),
        .adc_enable(adc_enable), .adc_conv_done(adc_conv_done),
        .wake_src(wake_src), .dom_clk_en(dom_clk_en),
        .periph_clk_en(periph_clk_en),
        .periph_reg_access(periph_reg_access),
        .comparator_mux_allow(comparator_mux_allow),
        .adc_powered(adc_powered), .adc_extended_conv(adc_extended_conv),
        .sleeping(sleeping), .wake_pulse(wake_pulse)
    );

    // ************************************************************
    // shared tasks
    // ************************************************************
    // compare one value, count it, report a mismatch at once
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // verdict and end of run, also reached from the watchdog
    task automatic summarize;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // one apb transfer; the request stands until pready is seen high
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        #1;
        // pready standing now is what the coming edge samples
        // no latency is assumed; the bound only stops a hang
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            #1;
            n++;
        end
        // a slave that never answers counts as a mismatch
        if (pready !== 1'b1) begin
            error_cnt++;
        end
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // let registered outputs follow a register or pin change
    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask

    // one-cycle sleep instruction
    task automatic do_sleep;
        @(posedge pclk);
        sleep_req <= 1'b1;
        @(posedge pclk);
        sleep_req <= 1'b0;
        #1;
    endtask

    // hold a wake source; lat 0 means it must be refused
    task automatic try_wake(input logic [14:0] src, input int lat);
        int n;
        n = 0;
        @(posedge pclk);
        wake_src <= scp_wake_type'(src);
        if (lat == 0) begin
            repeat (10) @(posedge pclk);
            #1;
            check(sleeping, 1'b1);
        end else begin
            do begin
                @(posedge pclk);
                #1;
                n++;
            end while (wake_pulse !== 1'b1 && n < 40);
            check(32'(n), 32'(lat));
            check(dom_clk_en, {6'h3F, timer_two_async_select});
        end
        @(posedge pclk);
        wake_src <= '0;
    endtask

    // ************************************************************
    // watchdog and main sequence
    // ************************************************************
    initial begin
        #200000;
        error_cnt++;
        summarize();
    end

    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = '0; pwdata = '0; sleep_req = 1'b0;
        crystal_selected = 1'b0; timer_two_async_select = 1'b0;
        adc_enable = 1'b0; adc_conv_done = 1'b0; wake_src = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(SCP_PCG_OFS, 1'b0, '0);
        check(rd, 32'h0);
        check(adc_extended_conv, 1'b1);
        apb(SCP_STAT_OFS, 1'b0, '0);
        check(rd, 32'h7E);
        apb(12'h00C, 1'b0, '0);
        check({rd[30:0], err}, 32'h1);
        // each gate bit but reserved bit 4 stops its own clock and register access
        // converter off before gating
        for (int b = 0; b < 8; b++) begin
            apb(SCP_PCG_OFS, 1'b1, 32'(1 << b));
            settle();
            check(periph_clk_en, 8'hEF & ~(8'h01 << b));
            check(periph_reg_access, 8'hEF & ~(8'h01 << b));
        end
        apb(SCP_PCG_OFS, 1'b1, 32'hFF);
        apb(SCP_PCG_OFS, 1'b0, '0);
        check(rd, 32'hEF);
        check(comparator_mux_allow, 1'b0);
        timer_two_async_select <= 1'b1;
        settle();
        check(periph_clk_en, 8'h40);
        timer_two_async_select <= 1'b0;
        // links set up again before use
        apb(SCP_PCG_OFS, 1'b1, 32'h0);
        settle();
        check(periph_clk_en, 8'hEF);
        check(comparator_mux_allow, 1'b1);
        // converter restart flag
        adc_conv_done <= 1'b1;
        @(posedge pclk);
        adc_conv_done <= 1'b0;
        adc_enable <= 1'b1;
        settle();
        check({adc_powered, adc_extended_conv}, 2'b11);
        adc_conv_done <= 1'b1;
        @(posedge pclk);
        adc_conv_done <= 1'b0;
        settle();
        check(adc_extended_conv, 1'b0);
        // reserved codes, and standby without a crystal, are ignored
        for (int c = 4; c < 8; c++) begin
            apb(SCP_SLEEP_OFS, 1'b1, 32'(c));
            do_sleep();
            check(sleeping, 1'b0);
        end
        crystal_selected <= 1'b1;
        // every mode: clocks, gated clocks, refused and accepted wake
        for (int i = 0; i < 6; i++) begin
            timer_two_async_select <= (i == 5);
            apb(SCP_SLEEP_OFS, 1'b1, {29'h0, m_code[i]});
            do_sleep();
            check(sleeping, 1'b1);
            check(dom_clk_en, m_clk[i]);
            check(periph_clk_en, m_pcg[i]);
            check(adc_powered, 1'b1);
            try_wake(m_rej[i], 0);
            try_wake(m_acc[i], m_lat[i]);
        end
        // converter off and on again gives an extended conversion
        // converter off outside the sweep
        adc_enable <= 1'b0;
        settle();
        adc_enable <= 1'b1;
        settle();
        check(adc_extended_conv, 1'b1);
        summarize();
    end
endmodule
